// ==== test/ptd_decoder_tb_top.sv ====
/*
 self-checking bench for the pulse train decoder.
 assumes min pulse 3 and sync 20 cycles, inputs changed at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module ptd_decoder_tb_top
	import ptd_pkg::*;
;
	logic      clk = 1'b0;
	logic      rst = 1'b1;
	logic      idleLvl = 1'b0;
	logic      pulseIn;
	logic      syncPause;
	logic      frameFull;
	ptd_chan_t chanOut;
	ptd_cfg_t  cfg = {20'h00003, 20'h00014, 1'b0};
	int        error_cnt = 0;
	int        check_count = 0;
	int        cyc = 0;
	always #25 clk = ~clk;
	ptd_pulse_src src (.clk(clk), .idleLvl(idleLvl), .pulseIn(pulseIn));
	ptd_decoder DUT (.clk(clk), .rst(rst), .cfg(cfg), .pulseIn(pulseIn),
		.chanOut(chanOut), .syncPause(syncPause), .frameFull(frameFull));
	task chk(input ptd_chan_t got, input ptd_chan_t exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task finish_test;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			error_cnt++;
			finish_test();
		end
	end
	task reset_dut(input logic fall);
		rst = 1'b1;
		idleLvl = fall;
		cfg.fallingEdge = fall;
		src.idle(5);
		rst = 1'b0;
		chk(chanOut, 7'h00);
	endtask : reset_dut
	task t_frame(input int n);
		for (int k = 0; k < n; k++) begin
			src.pulse(2, 8);
			chk(chanOut, 7'h01 << k);
			chk({6'h00, syncPause}, 7'h00);
		end
		if (n == 7) begin
			chk({6'h00, frameFull}, 7'h01);
			src.pulse(2, 8);
			chk(chanOut, 7'h40);
		end
		src.idle(30);
		chk({6'h00, syncPause}, 7'h01);
		chk(chanOut, 7'h00);
		chk({6'h00, frameFull}, 7'h00);
	endtask : t_frame
	task t_blank;
		src.pulse(1, 2);
		src.pulse(1, 8);
		chk(chanOut, 7'h01);
		src.idle(30);
	endtask : t_blank
	// third edge lands in the first cycle of the pause and must open a new frame
	task t_late;
		src.pulse(2, 8);
		src.pulse(2, 24);
		chk(chanOut, 7'h02);
		src.pulse(2, 8);
		chk(chanOut, 7'h01);
		src.idle(30);
	endtask : t_late
	// an extra pulse shifts later channels only until the next pause
	task t_extra;
		src.pulse(2, 8);
		src.pulse(2, 4);
		src.pulse(2, 8);
		chk(chanOut, 7'h04);
		src.idle(30);
		chk(chanOut, 7'h00);
		src.pulse(2, 8);
		chk(chanOut, 7'h01);
		src.idle(30);
	endtask : t_extra
	initial begin
		reset_dut(1'b0);
		t_frame(3);
		t_frame(7);
		t_blank();
		t_late();
		t_extra();
		reset_dut(1'b1);
		t_frame(2);
		finish_test();
	end
endmodule : ptd_decoder_tb_top
`default_nettype wire

// ==== test/ptd_pulse_src.sv ====
/*
 serial pulse source standing in for the receiver in front of the decoder.
 assumes the bench calls its tasks and picks each gap larger than its hi count.
*/
`timescale 1ns/1ps
`default_nettype none
module ptd_pulse_src (
	input  wire logic clk,
	input  wire logic idleLvl,
	output var  logic pulseIn
);
	initial pulseIn = 1'b0;
	// one pulse: leading edge, hi cycles active, idle up to gap cycles in all
	task automatic pulse(input int hi, input int gap);
		@(negedge clk);
		pulseIn = ~idleLvl;
		repeat (hi) @(negedge clk);
		pulseIn = idleLvl;
		repeat (gap - hi - 1) @(negedge clk);
	endtask : pulse
	task automatic idle(input int n);
		pulseIn = idleLvl;
		repeat (n) @(negedge clk);
	endtask : idle
endmodule : ptd_pulse_src
`default_nettype wire

// ==== verilog/ptd_decoder.sv ====
/*
 serial pulse train to parallel channel decoder with blanking and sync separation.
 assumes a single 20 MHz clock, synchronous input and a static configuration.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ptd_regs.svh"
module ptd_decoder
	import ptd_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     rst,
	input  wire ptd_cfg_t cfg,
	input  wire logic     pulseIn,
	output var  ptd_chan_t chanOut,
	output var  logic     syncPause,
	output var  logic     frameFull
);
	logic                  inPrev;
	logic                  pulseLatch;
	logic [`PTD_TMR_W-1:0] minTimer;
	logic [`PTD_TMR_W-1:0] syncTimer;
	logic [`PTD_CNT_W-1:0] count;

	wire  rawEdge         = cfg.fallingEdge ? (inPrev & ~pulseIn) : (~inPrev & pulseIn);
	wire  syncExpired     = (syncTimer >= cfg.syncCycles) & ~pulseLatch;
	wire  frame_full_gate = (count == `PTD_STATE_FULL) & ~syncExpired;
	wire  input_gate      = rawEdge & ~pulseLatch & ~frame_full_gate;
	wire  [`PTD_TMR_W-1:0] minTimerInc = minTimer + 20'h00001;
	wire  minDone         = pulseLatch & (minTimerInc >= cfg.minPulseCycles);

	// an edge in the very cycle the pause is seen opens a new frame, so count from idle
	wire  [`PTD_CNT_W-1:0] countBase  = syncExpired ? `PTD_STATE_IDLE : count;
	wire  [`PTD_CNT_W-1:0] next_count = input_gate ? countBase + 3'h1 : countBase;
	wire  ptd_chan_t       next_chanOut;
	wire  next_syncPause  = syncExpired & ~input_gate;
	wire  next_frameFull  = (next_count == `PTD_STATE_FULL);

	always_ff @(posedge clk) begin
		if (rst)
			inPrev <= 1'b0;
		else
			inPrev <= pulseIn;
	end

	// pulse latch and minimum pulse timer
	always_ff @(posedge clk) begin
		if (rst) begin
			pulseLatch <= 1'b0;
			minTimer   <= '0;
		end else if (input_gate) begin
			pulseLatch <= 1'b1;
			minTimer   <= '0;
		end else if (minDone) begin
			pulseLatch <= 1'b0;
			minTimer   <= '0;
		end else if (pulseLatch) begin
			minTimer   <= minTimer + 20'h00001;
		end
	end

	// sync timer: held clear while latch set, saturates after the interval
	always_ff @(posedge clk) begin
		if (rst || pulseLatch || input_gate)
			syncTimer <= '0;
		else if (!syncExpired)
			syncTimer <= syncTimer + 20'h00001;
	end

	// counter-decoder
	always_ff @(posedge clk) begin
		if (rst)
			count <= `PTD_STATE_IDLE;
		else
			count <= next_count;
	end

	genvar gi;
	generate
		for (gi = 0; gi < `PTD_NUM_CH; gi++) begin : g_chan
			assign next_chanOut[gi] = (next_count == 3'(gi + 1));
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst)
			chanOut <= '0;
		else
			chanOut <= next_chanOut;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			syncPause <= 1'b0;
			frameFull <= 1'b0;
		end else begin
			syncPause <= next_syncPause;
			frameFull <= next_frameFull;
		end
	end

	// edge gate and blanking
	a_full_blocks: assert property (@(posedge clk) disable iff (rst)
		(count == `PTD_STATE_FULL && !syncExpired) |-> !input_gate)
		else $error("edge accepted in full frame state");

	a_latch_blank: assert property (@(posedge clk) disable iff (rst)
		pulseLatch |-> !input_gate)
		else $error("edge accepted during blanking");

	a_edge_advance: assert property (@(posedge clk) disable iff (rst)
		(input_gate && !syncExpired) |=> (count == $past(count) + 3'h1) && pulseLatch)
		else $error("accepted edge did not advance counter");

	a_min_width: assert property (@(posedge clk) disable iff (rst)
		(input_gate && cfg.minPulseCycles == 20'h00003) |=> pulseLatch[*3] ##1 !pulseLatch)
		else $error("minimum pulse width wrong");

	a_edge_sets_latch: assert property (@(posedge clk) disable iff (rst)
		input_gate |=> pulseLatch && minTimer == '0)
		else $error("accepted edge did not start the minimum pulse");

	a_timer_idle: assert property (@(posedge clk) disable iff (rst)
		!pulseLatch |-> minTimer == '0)
		else $error("minimum pulse timer running with latch clear");

	a_blank_timer: assert property (@(posedge clk) disable iff (rst)
		(pulseLatch && cfg.minPulseCycles != 20'h00000) |-> minTimer < cfg.minPulseCycles)
		else $error("minimum pulse timer ran past its interval");

	a_latch_release: assert property (@(posedge clk) disable iff (rst)
		minDone |=> !pulseLatch)
		else $error("latch not released at end of minimum pulse");

	a_edge_polarity: assert property (@(posedge clk) disable iff (rst)
		input_gate |-> (cfg.fallingEdge ? !pulseIn : pulseIn))
		else $error("edge of the wrong polarity accepted");

	// counter and channel outputs
	a_pause_idle: assert property (@(posedge clk) disable iff (rst)
		(syncExpired && !input_gate) |=> count == `PTD_STATE_IDLE)
		else $error("pause did not idle counter");

	a_first_chan: assert property (@(posedge clk) disable iff (rst)
		(input_gate && syncExpired) |=> count == 3'h1 && chanOut == 7'h01)
		else $error("edge at pause did not open a new frame");

	a_pause_counter: assert property (@(posedge clk) disable iff (rst)
		syncPause |-> count == `PTD_STATE_IDLE && chanOut == '0)
		else $error("pause flagged with counter not idle");

	a_short_reset: assert property (@(posedge clk) disable iff (rst)
		(syncExpired && !input_gate && count != `PTD_STATE_FULL) |=> count == `PTD_STATE_IDLE && chanOut == '0)
		else $error("short frame not reset at sync expiry");

	a_full_holds: assert property (@(posedge clk) disable iff (rst)
		(count == `PTD_STATE_FULL && !syncExpired) |=> count == `PTD_STATE_FULL)
		else $error("full frame state left before sync expiry");

	a_full_flag: assert property (@(posedge clk) disable iff (rst)
		frameFull == (count == `PTD_STATE_FULL))
		else $error("full frame flag disagrees with counter");

	a_no_wrap: assert property (@(posedge clk) disable iff (rst)
		(count == `PTD_STATE_FULL) |=> count == `PTD_STATE_FULL || count == `PTD_STATE_IDLE || count == 3'h1)
		else $error("counter wrapped past the last channel");

	a_full_stable: assert property (@(posedge clk) disable iff (rst)
		(frame_full_gate && rawEdge) |=> $stable(chanOut))
		else $error("blocked edge changed the channel outputs");

	a_chan_onehot: assert property (@(posedge clk) disable iff (rst)
		$onehot0(chanOut))
		else $error("more than one channel output high");

	a_chan_state: assert property (@(posedge clk) disable iff (rst)
		(count != `PTD_STATE_IDLE) |-> chanOut[count - 3'h1])
		else $error("selected channel output low");

	a_idle_low: assert property (@(posedge clk) disable iff (rst)
		(count == `PTD_STATE_IDLE) |-> chanOut == '0)
		else $error("channel output high in idle state");

	a_no_pulse_low: assert property (@(posedge clk) disable iff (rst)
		(syncExpired && !input_gate)[*2] |-> chanOut == '0)
		else $error("outputs high without pulses");

	// sync separator and reset
	a_sync_clear: assert property (@(posedge clk) disable iff (rst)
		pulseLatch |=> syncTimer == '0)
		else $error("sync timer not cleared by latch");

	a_sync_count: assert property (@(posedge clk) disable iff (rst)
		(!pulseLatch && !input_gate && !syncExpired) |=> syncTimer == $past(syncTimer) + 20'h00001)
		else $error("sync timer not timing after latch clear");

	a_sync_bound: assert property (@(posedge clk) disable iff (rst)
		syncTimer <= cfg.syncCycles)
		else $error("sync timer ran past its interval");

	a_pause_flag: assert property (@(posedge clk) disable iff (rst)
		(syncExpired && !input_gate) |=> syncPause)
		else $error("expired sync interval not flagged");

	a_pause_quiet: assert property (@(posedge clk) disable iff (rst)
		pulseLatch |=> !syncPause)
		else $error("pause flagged during channel spacing");

	a_reset_clear: assert property (@(posedge clk)
		rst |=> count == `PTD_STATE_IDLE && chanOut == '0 && syncTimer == '0
			&& !pulseLatch && !syncPause && !frameFull)
		else $error("reset did not clear state");
endmodule : ptd_decoder
`default_nettype wire

// ==== verilog/ptd_pkg.sv ====
/*
 types for the pulse train decoder.
 assumes ptd_regs.svh is on the include path.
*/
`default_nettype none
`include "ptd_regs.svh"
package ptd_pkg;
	typedef struct packed {
		logic [`PTD_TMR_W-1:0] minPulseCycles;
		logic [`PTD_TMR_W-1:0] syncCycles;
		logic                  fallingEdge;
	} ptd_cfg_t;
	typedef logic [`PTD_NUM_CH-1:0] ptd_chan_t;
endpackage : ptd_pkg
`default_nettype wire

// ==== verilog/ptd_regs.svh ====
/*
 pulse train decoder constants: channel count, counter states, default timer counts.
 assumes a 20 MHz system clock.
*/
`ifndef PTD_REGS_SVH
`define PTD_REGS_SVH
`define PTD_NUM_CH       7
`define PTD_CNT_W        3
`define PTD_TMR_W        20
`define PTD_CLK_NS       50
`define PTD_MIN_PULSE_NS 500000
`define PTD_SYNC_NS      6000000
`define PTD_MIN_PULSE_CYC ((`PTD_MIN_PULSE_NS + `PTD_CLK_NS - 1) / `PTD_CLK_NS)
`define PTD_SYNC_CYC      ((`PTD_SYNC_NS + `PTD_CLK_NS - 1) / `PTD_CLK_NS)
`define PTD_STATE_IDLE   3'h0
`define PTD_STATE_FULL   3'h7
`endif
